//--- bfs_map.vh
`ifndef BFS_MAP_VH
`define BFS_MAP_VH

// Command codes of the registers held here
`define BFS_CMD_FAULT_SUMMARY  8'h78
`define BFS_CMD_BOARD_MODEL    8'h9a
`define BFS_CMD_BOARD_REVISION 8'h9b
`define BFS_CMD_BOARD_DATE     8'h9d

// Page values
`define BFS_PAGE_CHAN_A        8'h00
`define BFS_PAGE_CHAN_B        8'h01
`define BFS_PAGE_ALL           8'hff

// Widths
`define BFS_ID_WIDTH           16
`define BFS_DETAIL_WIDTH       9

// Detailed flag positions
`define BFS_DET_VOUT_OV        0
`define BFS_DET_VOUT_UV        1
`define BFS_DET_IOUT_OC        2
`define BFS_DET_IOUT_OC_WARN   3
`define BFS_DET_VIN_UV         4
`define BFS_DET_OT_FAULT       5
`define BFS_DET_OT_WARN        6
`define BFS_DET_CML_COMM       7
`define BFS_DET_CML_MEM        8

// Fault summary byte fields
`define BFS_SUM_BUSY           7
`define BFS_SUM_OFF            6
`define BFS_SUM_VOUT_OV        5
`define BFS_SUM_IOUT_OC        4
`define BFS_SUM_VIN_UV         3
`define BFS_SUM_TEMP           2
`define BFS_SUM_CML            1
`define BFS_SUM_OTHER          0

// Factory contents of the identification words
`define BFS_RST_BOARD_MODEL    16'h0000
`define BFS_RST_BOARD_REVISION 16'h0001
`define BFS_RST_BOARD_DATE     16'h0000

`endif

//--- bfs_id_word.v
`timescale 1ns/1ps
`include "bfs_map.vh"

module bfs_id_word #(
  parameter [`BFS_ID_WIDTH-1:0] FACTORY_VALUE = 16'h0000
) (
  // Clock and reset
  input  wire                     clk_sys_i,
  input  wire                     sys_rst_i,
  // Nonvolatile backup
  input  wire                     nvm_load_i,
  input  wire [`BFS_ID_WIDTH-1:0] nvm_value_i,
  // Host write
  input  wire                     wr_i,
  input  wire [`BFS_ID_WIDTH-1:0] wdata_i,
  // Stored word
  output reg  [`BFS_ID_WIDTH-1:0] value_o
);

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      value_o <= FACTORY_VALUE;
    end else if (nvm_load_i) begin
      value_o <= nvm_value_i;
    end else if (wr_i) begin
      value_o <= wdata_i;
    end
  end

endmodule

//--- bfs_chan_status.v
`timescale 1ns/1ps
`include "bfs_map.vh"

module bfs_chan_status (
  // Clock and reset
  input  wire                        clk_sys_i,
  input  wire                        sys_rst_i,
  // Fault events and clears
  input  wire [`BFS_DETAIL_WIDTH-1:0] event_i,
  input  wire [`BFS_DETAIL_WIDTH-1:0] detail_clr_i,
  input  wire                        clear_all_i,
  input  wire                        delivering_i,
  // State
  output reg  [`BFS_DETAIL_WIDTH-1:0] detail_o,
  output reg  [7:0]                  summary_o
);

  reg [`BFS_DETAIL_WIDTH-1:0] next_detail;
  reg [7:0]                   next_summary;

  always @* begin
    // Set wins over any clear in the same cycle
    next_detail = event_i | (detail_o & ~detail_clr_i & {`BFS_DETAIL_WIDTH{~clear_all_i}});
    next_summary = 8'h00;
    next_summary[`BFS_SUM_BUSY]    = 1'b0;
    next_summary[`BFS_SUM_OFF]     = ~delivering_i;
    next_summary[`BFS_SUM_VOUT_OV] = next_detail[`BFS_DET_VOUT_OV];
    next_summary[`BFS_SUM_IOUT_OC] = next_detail[`BFS_DET_IOUT_OC];
    next_summary[`BFS_SUM_VIN_UV]  = next_detail[`BFS_DET_VIN_UV];
    next_summary[`BFS_SUM_TEMP]    = next_detail[`BFS_DET_OT_FAULT] |
                                     next_detail[`BFS_DET_OT_WARN];
    next_summary[`BFS_SUM_CML]     = next_detail[`BFS_DET_CML_COMM] |
                                     next_detail[`BFS_DET_CML_MEM];
    next_summary[`BFS_SUM_OTHER]   = next_detail[`BFS_DET_VOUT_UV] |
                                     next_detail[`BFS_DET_IOUT_OC_WARN];
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      detail_o  <= {`BFS_DETAIL_WIDTH{1'b0}};
      summary_o <= 8'h40;
    end else begin
      detail_o  <= next_detail;
      summary_o <= next_summary;
    end
  end

endmodule

//--- bfs_board_id_status.v
`timescale 1ns/1ps
`include "bfs_map.vh"


module bfs_board_id_status (
  // Clock and reset
  input  wire                         clk_sys_i,
  input  wire                         sys_rst_i,
  // Decoded host transaction
  input  wire                         txn_wr_i,
  input  wire                         txn_rd_i,
  input  wire [7:0]                   cmd_i,
  input  wire [7:0]                   page_i,
  input  wire [`BFS_ID_WIDTH-1:0]     wdata_i,
  input  wire                         clear_faults_i,
  // Detailed status write-one clears, per channel
  input  wire [`BFS_DETAIL_WIDTH-1:0] detail_clr_a_i,
  input  wire [`BFS_DETAIL_WIDTH-1:0] detail_clr_b_i,
  // Fault sources, per channel
  input  wire [`BFS_DETAIL_WIDTH-1:0] event_a_i,
  input  wire [`BFS_DETAIL_WIDTH-1:0] event_b_i,
  input  wire                         delivering_a_i,
  input  wire                         delivering_b_i,
  // Nonvolatile backup
  input  wire                         nvm_load_i,
  input  wire [`BFS_ID_WIDTH-1:0]     nvm_model_i,
  input  wire [`BFS_ID_WIDTH-1:0]     nvm_revision_i,
  input  wire [`BFS_ID_WIDTH-1:0]     nvm_date_i,
  // Read answer
  output reg                          rd_valid_o,
  output reg  [`BFS_ID_WIDTH-1:0]     rdata_o,
  // Status to the rest of the device
  output reg  [`BFS_DETAIL_WIDTH-1:0] detail_a_o,
  output reg  [`BFS_DETAIL_WIDTH-1:0] detail_b_o,
  output reg                          invalid_wr_o,
  output reg                          alert_o
);

  // Page decode; FFh reads as channel A
  wire sel_b   = (page_i == `BFS_PAGE_CHAN_B);
  wire sel_a_w = (page_i == `BFS_PAGE_CHAN_A) | (page_i == `BFS_PAGE_ALL);
  wire sel_b_w = sel_b | (page_i == `BFS_PAGE_ALL);

  reg wr_model;
  reg wr_revision;
  reg wr_date;
  reg wr_bad;

  always @* begin
    wr_model    = 1'b0;
    wr_revision = 1'b0;
    wr_date     = 1'b0;
    wr_bad      = 1'b0;
    if (!txn_wr_i) begin
      wr_bad = 1'b0;
    end else if (cmd_i == `BFS_CMD_BOARD_MODEL) begin
      wr_model = 1'b1;
    end else if (cmd_i == `BFS_CMD_BOARD_REVISION) begin
      wr_revision = 1'b1;
    end else if (cmd_i == `BFS_CMD_BOARD_DATE) begin
      wr_date = 1'b1;
    end else if (cmd_i == `BFS_CMD_FAULT_SUMMARY) begin
      wr_bad = 1'b1;
    end
  end

  wire [`BFS_ID_WIDTH-1:0] model_word;
  wire [`BFS_ID_WIDTH-1:0] revision_word;
  wire [`BFS_ID_WIDTH-1:0] date_word;

  // One storage per word, reached whatever the page holds
  bfs_id_word #(.FACTORY_VALUE(`BFS_RST_BOARD_MODEL)) u_model (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .nvm_load_i  (nvm_load_i),
    .nvm_value_i (nvm_model_i),
    .wr_i        (wr_model),
    .wdata_i     (wdata_i),
    .value_o     (model_word)
  );

  bfs_id_word #(.FACTORY_VALUE(`BFS_RST_BOARD_REVISION)) u_revision (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .nvm_load_i  (nvm_load_i),
    .nvm_value_i (nvm_revision_i),
    .wr_i        (wr_revision),
    .wdata_i     (wdata_i),
    .value_o     (revision_word)
  );

  bfs_id_word #(.FACTORY_VALUE(`BFS_RST_BOARD_DATE)) u_date (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .nvm_load_i  (nvm_load_i),
    .nvm_value_i (nvm_date_i),
    .wr_i        (wr_date),
    .wdata_i     (wdata_i),
    .value_o     (date_word)
  );

  // Invalid write raises a communication fault on the addressed page(s)
  wire [`BFS_DETAIL_WIDTH-1:0] comm_evt = {{(`BFS_DETAIL_WIDTH-1-`BFS_DET_CML_COMM){1'b0}},
                                           1'b1, {`BFS_DET_CML_COMM{1'b0}}};
  wire [`BFS_DETAIL_WIDTH-1:0] evt_a = event_a_i | (comm_evt & {`BFS_DETAIL_WIDTH{wr_bad & sel_a_w}});
  wire [`BFS_DETAIL_WIDTH-1:0] evt_b = event_b_i | (comm_evt & {`BFS_DETAIL_WIDTH{wr_bad & sel_b_w}});

  wire [`BFS_DETAIL_WIDTH-1:0] det_a;
  wire [`BFS_DETAIL_WIDTH-1:0] det_b;
  wire [7:0]                   sum_a;
  wire [7:0]                   sum_b;

  bfs_chan_status u_chan_a (
    .clk_sys_i    (clk_sys_i),
    .sys_rst_i    (sys_rst_i),
    .event_i      (evt_a),
    .detail_clr_i (detail_clr_a_i),
    .clear_all_i  (clear_faults_i & sel_a_w),
    .delivering_i (delivering_a_i),
    .detail_o     (det_a),
    .summary_o    (sum_a)
  );

  bfs_chan_status u_chan_b (
    .clk_sys_i    (clk_sys_i),
    .sys_rst_i    (sys_rst_i),
    .event_i      (evt_b),
    .detail_clr_i (detail_clr_b_i),
    .clear_all_i  (clear_faults_i & sel_b_w),
    .delivering_i (delivering_b_i),
    .detail_o     (det_b),
    .summary_o    (sum_b)
  );

  // Read answer one cycle after the request
  reg [`BFS_ID_WIDTH-1:0] next_rdata;
  reg                     next_hit;

  always @* begin
    next_rdata = {`BFS_ID_WIDTH{1'b0}};
    next_hit   = 1'b1;
    if (cmd_i == `BFS_CMD_FAULT_SUMMARY) begin
      next_rdata = {8'h00, (sel_b ? sum_b : sum_a)};
    end else if (cmd_i == `BFS_CMD_BOARD_MODEL) begin
      next_rdata = model_word;
    end else if (cmd_i == `BFS_CMD_BOARD_REVISION) begin
      next_rdata = revision_word;
    end else if (cmd_i == `BFS_CMD_BOARD_DATE) begin
      next_rdata = date_word;
    end else begin
      next_hit = 1'b0;
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_valid_o   <= 1'b0;
      rdata_o      <= {`BFS_ID_WIDTH{1'b0}};
      detail_a_o   <= {`BFS_DETAIL_WIDTH{1'b0}};
      detail_b_o   <= {`BFS_DETAIL_WIDTH{1'b0}};
      invalid_wr_o <= 1'b0;
      alert_o      <= 1'b0;
    end else begin
      rd_valid_o   <= txn_rd_i & next_hit;
      if (txn_rd_i & next_hit) begin
        rdata_o <= next_rdata;
      end
      detail_a_o   <= det_a;
      detail_b_o   <= det_b;
      invalid_wr_o <= wr_bad;
      // Alert follows any latched summary flag, so clearing the flags drops it
      alert_o      <= (|sum_a[`BFS_SUM_VOUT_OV:0]) | (|sum_b[`BFS_SUM_VOUT_OV:0]);
    end
  end

endmodule

//--- bfs_board_id_status_checker.sv
`timescale 1ns/1ps
`include "bfs_map.vh"
module bfs_chk (
  input wire                         clk_sys_i,
  input wire                         sys_rst_i,
  input wire                         txn_wr_i,
  input wire                         txn_rd_i,
  input wire [7:0]                   cmd_i,
  input wire [7:0]                   page_i,
  input wire                         clear_faults_i,
  input wire [`BFS_DETAIL_WIDTH-1:0] detail_clr_a_i,
  input wire [`BFS_DETAIL_WIDTH-1:0] event_a_i,
  input wire                         rd_valid_o,
  input wire [`BFS_ID_WIDTH-1:0]     rdata_o,
  input wire [`BFS_DETAIL_WIDTH-1:0] detail_a_o,
  input wire                         invalid_wr_o,
  input wire                         alert_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_sum_rd; txn_rd_i && cmd_i == 8'h78; endsequence
  sequence s_bad_wr; txn_wr_i && cmd_i == 8'h78 && page_i == 8'h00; endsequence
  // A clear in the next cycle may legally undo a flag, so it is excluded
  sequence s_ov_kept; event_a_i[0] ##1 !clear_faults_i && !detail_clr_a_i[0]; endsequence
  rd_answer_a: assert property (s_sum_rd |=> rd_valid_o) else $error("summary read unanswered");
  busy_zero_a: assert property (s_sum_rd |=> rdata_o[15:7] == 9'h000) else $error("busy bit set");
  wr_refused_a: assert property (s_bad_wr |=> invalid_wr_o) else $error("summary write accepted");
  wr_silent_a: assert property (txn_wr_i && !txn_rd_i |=> !rd_valid_o) else $error("write answered");
  ov_latch_a: assert property (s_ov_kept |=> detail_a_o[0]) else $error("overvoltage not latched");
  flag_hold_a: assert property ($past(detail_a_o[2]) && !$past(clear_faults_i, 2)
    && !$past(detail_clr_a_i[2], 2) |-> detail_a_o[2]) else $error("flag dropped");
  w1c_clear_a: assert property (detail_clr_a_i[0] && !event_a_i[0] |-> ##2 !detail_a_o[0]) else $error("not cleared");
  bad_cml_a: assert property (s_bad_wr ##1 !clear_faults_i && !detail_clr_a_i[7]
    |=> detail_a_o[7] && alert_o) else $error("comm fault missing");
endmodule
bind bfs_board_id_status bfs_chk u_chk (.clk_sys_i, .sys_rst_i, .txn_wr_i, .txn_rd_i, .cmd_i, .page_i,
  .clear_faults_i, .detail_clr_a_i, .event_a_i, .rd_valid_o, .rdata_o, .detail_a_o, .invalid_wr_o, .alert_o);

//--- bfs_host_model.sv
`timescale 1ns/1ps
module bfs_host_model (
  input  wire         clk_sys_i,
  input  wire         rd_valid_i,
  input  wire  [15:0] rdata_i,
  input  wire         invalid_wr_i,
  output logic        txn_wr_o = 1'b0,
  output logic        txn_rd_o = 1'b0,
  output logic [7:0]  cmd_o = 8'h00,
  output logic [15:0] wdata_o = 16'h0000
);
  // Whole-word read, answer awaited up to four edges after the request
  task automatic rd(input [7:0] c, output logic [15:0] d);
    int n;
    @(posedge clk_sys_i);
    txn_rd_o <= 1'b1;
    cmd_o <= c;
    @(posedge clk_sys_i);
    txn_rd_o <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!rd_valid_i && n < 4);
    // A read that is never answered yields unknown data, so no stale word can pass
    d = rd_valid_i ? rdata_i : 16'hxxxx;
  endtask
  task automatic wr(input [7:0] c, input [15:0] d, output logic inv);
    @(posedge clk_sys_i);
    txn_wr_o <= 1'b1;
    cmd_o <= c;
    wdata_o <= d;
    @(posedge clk_sys_i);
    txn_wr_o <= 1'b0;
    // Stale data is not left on the bus
    wdata_o <= ~d;
    @(posedge clk_sys_i);
    inv = invalid_wr_i;
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "bfs_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        clk_sys_i = 0, sys_rst_i = 1, cf = 0, dlv_a = 1, dlv_b = 1, nvm_ld = 0;
  logic        txn_wr, txn_rd, rd_valid, inv_wr, alert, inv;
  logic [7:0]  page = 8'h00, cmd;
  logic [8:0]  clr_a = 0, clr_b = 0, ev_a = 0, ev_b = 0, det_a, det_b;
  logic [15:0] wdata, rdata, d;
  logic [7:0]  sum_tab [9] = '{8'h20, 8'h01, 8'h10, 8'h01, 8'h08, 8'h04, 8'h04, 8'h02, 8'h02};
  int          fail_count = 0, n_checks = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  bfs_host_model host (.clk_sys_i(clk_sys_i), .rd_valid_i(rd_valid), .rdata_i(rdata), .invalid_wr_i(inv_wr),
    .txn_wr_o(txn_wr), .txn_rd_o(txn_rd), .cmd_o(cmd), .wdata_o(wdata));
  bfs_board_id_status uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .txn_wr_i(txn_wr), .txn_rd_i(txn_rd),
    .cmd_i(cmd), .page_i(page), .wdata_i(wdata), .clear_faults_i(cf), .detail_clr_a_i(clr_a),
    .detail_clr_b_i(clr_b), .event_a_i(ev_a), .event_b_i(ev_b), .delivering_a_i(dlv_a), .delivering_b_i(dlv_b),
    .nvm_load_i(nvm_ld), .nvm_model_i(16'h1234), .nvm_revision_i(16'hfedc), .nvm_date_i(16'h0a5a),
    .rd_valid_o(rd_valid), .rdata_o(rdata), .detail_a_o(det_a), .detail_b_o(det_b), .invalid_wr_o(inv_wr),
    .alert_o(alert));
  task automatic chk_rd(input [7:0] c, input [15:0] e);
    host.rd(c, d);
    `CHK("rdata", e, d)
  endtask
  // One-cycle pulses on events of both channels, channel A detailed clears and clear-faults
  task automatic kick(input [8:0] ea, eb, ca, input c);
    @(posedge clk_sys_i);
    ev_a <= ea;
    ev_b <= eb;
    clr_a <= ca;
    cf <= c;
    @(posedge clk_sys_i);
    {ev_a, ev_b, clr_a, cf} <= '0;
  endtask
  task automatic t_ids;
    chk_rd(8'h9a, `BFS_RST_BOARD_MODEL);
    chk_rd(8'h9b, `BFS_RST_BOARD_REVISION);
    @(posedge clk_sys_i) nvm_ld <= 1;
    @(posedge clk_sys_i) nvm_ld <= 0;
    chk_rd(8'h9a, 16'h1234);
    chk_rd(8'h9d, 16'h0a5a);
    @(posedge clk_sys_i) page <= 8'h01;
    host.wr(8'h9a, 16'hbeef, inv);
    `CHK("inv", 1'b0, inv)
    @(posedge clk_sys_i) page <= 8'hff;
    host.wr(8'h9b, 16'h8001, inv);
    @(posedge clk_sys_i) page <= 8'h00;
    chk_rd(8'h9a, 16'hbeef);
    chk_rd(8'h9b, 16'h8001);
    $display("test ids done");
  endtask
  task automatic t_bits;
    for (int i = 0; i < 9; i++) begin
      kick(9'h1 << i, 0, 0, 0);
      chk_rd(8'h78, {8'h00, sum_tab[i]});
      `CHK("detail", 9'h1 << i, det_a)
      kick(0, 0, 0, 1);
      chk_rd(8'h78, 16'h0000);
    end
    $display("test bits done");
  endtask
  task automatic t_pages;
    @(posedge clk_sys_i) dlv_b <= 0;
    kick(9'h001, 9'h004, 0, 0);
    chk_rd(8'h78, 16'h0020);
    `CHK("det_b", 9'h004, det_b)
    @(posedge clk_sys_i) page <= 8'h01;
    chk_rd(8'h78, 16'h0050);
    kick(0, 0, 0, 1);
    chk_rd(8'h78, 16'h0040);
    @(posedge clk_sys_i) page <= 8'hff;
    chk_rd(8'h78, 16'h0020);
    kick(0, 0, 9'h001, 0);
    chk_rd(8'h78, 16'h0000);
    @(posedge clk_sys_i) page <= 8'h01;
    dlv_b <= 1;
    chk_rd(8'h78, 16'h0000);
    $display("test pages done");
  endtask
  task automatic t_bad;
    @(posedge clk_sys_i) page <= 8'h00;
    host.wr(8'h78, 16'h00ff, inv);
    `CHK("inv", 1'b1, inv)
    chk_rd(8'h78, 16'h0002);
    `CHK("alert", 1'b1, alert)
    chk_rd(8'h9a, 16'hbeef);
    kick(0, 0, 0, 1);
    chk_rd(8'h78, 16'h0000);
    `CHK("alert", 1'b0, alert)
    @(posedge clk_sys_i) page <= 8'hff;
    host.wr(8'h78, 16'h0000, inv);
    `CHK("inv", 1'b1, inv)
    chk_rd(8'h78, 16'h0002);
    `CHK("det_b", 9'h080, det_b)
    kick(0, 0, 0, 1);
    chk_rd(8'h78, 16'h0000);
    `CHK("det_b", 9'h000, det_b)
    `CHK("alert", 1'b0, alert)
    $display("test bad write done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 0;
    t_ids;
    t_bits;
    t_pages;
    t_bad;
    test_done;
  end
endmodule
